// >>> logic/bec_cfg.svh
// Purpose: constants for the bulk endpoint direction and buffer select control
// Assumes: 8-bit register port, one 125 MHz clock, synchronous active-low reset
// Notes: offsets, field positions, reset values and widths live here
`ifndef BEC_CFG_SVH
`define BEC_CFG_SVH

`define BEC_ADDR_W 8
`define BEC_DATA_W 8
`define BEC_CNT_W 10
`define BEC_BUF_BYTES 512
`define BEC_STAT_W 3

`define BEC_OFS_CTL 8'hb4
`define BEC_OFS_STATUS 8'hc0
`define BEC_OFS_MASK 8'hc1
`define BEC_OFS_DISK_CTL 8'hc2
`define BEC_OFS_CNT_A_LO 8'hc4
`define BEC_OFS_CNT_A_HI 8'hc5
`define BEC_OFS_CNT_B_LO 8'hc6
`define BEC_OFS_CNT_B_HI 8'hc7

`define BEC_CTL_DIR_BIT 7
`define BEC_CTL_QUAL_BIT 6
`define BEC_CTL_SEL_BIT 5
`define BEC_DISK_AUTO_BIT 3

`define BEC_ST_ERR_BIT 0
`define BEC_ST_DONE_A_BIT 1
`define BEC_ST_DONE_B_BIT 2

`define BEC_CTL_RESET 8'h00
`define BEC_MASK_RESET 3'h0

`endif

// >>> logic/bec_pkg.sv
// Purpose: shared types of the bulk endpoint control block
// Assumes: constants come from the cfg header
// Notes: the state struct of the top module is declared here
`include "bec_cfg.svh"

package bec_pkg;

   typedef enum logic [0:0] {
      BEC_FILL_IDLE = 1'b0,
      BEC_FILL_BUSY = 1'b1
   } bec_fill_e;

   typedef logic [`BEC_CNT_W-1:0] bec_count_t;

   typedef struct packed {
      logic flow_dir;
      logic wr_sel;
      logic auto_alt;
      logic [`BEC_STAT_W-1:0] status;
      logic [`BEC_STAT_W-1:0] mask;
      logic [`BEC_DATA_W-1:0] rdata;
      logic irq;
      bec_fill_e fill;
   } bec_top_s;

   typedef struct packed {
      logic err;
   } bec_tok_s;

   typedef struct packed {
      bec_count_t count;
   } bec_cnt_s;

endpackage

// >>> logic/bec_byte_counter.sv
// Purpose: byte count of the most recent fill of one 512-byte buffer
// Assumes: inc_in is one pulse per byte stored into this buffer
// Notes: the count saturates at the buffer depth instead of wrapping
`include "bec_cfg.svh"

module bec_byte_counter #(
   parameter int DEPTH = `BEC_BUF_BYTES
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic clear_in,
   input wire logic inc_in,
   output bec_pkg::bec_count_t count_out
);

   if (DEPTH < 1 || DEPTH > (1 << `BEC_CNT_W) - 1) begin : g_bad_depth
      $error("depth does not fit the byte count width");
   end

   localparam bec_pkg::bec_count_t LIMIT = bec_pkg::bec_count_t'(DEPTH);

   bec_pkg::bec_cnt_s state_reg;
   bec_pkg::bec_cnt_s state_next;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      if (clear_in) begin
         state_next.count = '0;
      end else if (inc_in && state_reg.count != LIMIT) begin
         state_next.count = state_reg.count + bec_pkg::bec_count_t'(1);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign count_out = state_reg.count;

   ////////////////////////////////////////////////////////////////////////////
   chk_count_clear_zero: assert property (
      @(posedge clk_in) disable iff (!reset_n_in) clear_in |=> count_out == '0)
      else $error("byte count not cleared");

   chk_count_inc_step: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      (!clear_in && inc_in && count_out < LIMIT) |=> count_out == $past(count_out) + 1)
      else $error("byte count did not step by one");

endmodule

// >>> logic/bec_token_check.sv
// Purpose: flags a bulk token whose type is wrong for the flow direction
// Assumes: token_valid_in is one pulse per bulk endpoint token
// Notes: error pulse is registered, so it appears one cycle after the token
module bec_token_check (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic token_valid_in,
   input wire logic token_is_in_in,
   input wire logic flow_dir_in,
   output logic error_pulse_out
);

   bec_pkg::bec_tok_s state_reg;
   bec_pkg::bec_tok_s state_next;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      state_next.err = 1'b0;
      if (token_valid_in) begin
         if (flow_dir_in && !token_is_in_in) begin
            state_next.err = 1'b1;
         end
         if (!flow_dir_in && token_is_in_in) begin
            state_next.err = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign error_pulse_out = state_reg.err;

   ////////////////////////////////////////////////////////////////////////////
   chk_out_token_err: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      (token_valid_in && flow_dir_in && !token_is_in_in) |=> error_pulse_out)
      else $error("out token in disk-to-usb direction not flagged");

   chk_in_token_err: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      (token_valid_in && !flow_dir_in && token_is_in_in) |=> error_pulse_out)
      else $error("in token in usb-to-disk direction not flagged");

   chk_no_false_err: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      !(token_valid_in && (flow_dir_in ^ token_is_in_in)) |=> !error_pulse_out)
      else $error("token error raised without a wrong token");

endmodule

// >>> logic/bec_top.sv
// Purpose: bulk endpoint direction, write buffer select and byte count registers
// Assumes: register strobes are one cycle, never together; byte strobes follow
//          the select bit; fill_done_in pulses once at the end of each fill
// Notes: read data stand only in the cycle after the read strobe
`include "bec_cfg.svh"

module bec_top #(
   parameter int BUF_BYTES = `BEC_BUF_BYTES
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   // register port
   input wire logic [`BEC_ADDR_W-1:0] addr_in,
   input wire logic [`BEC_DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [`BEC_DATA_W-1:0] rdata_out,
   // serial interface engine side
   input wire logic token_valid_in,
   input wire logic token_is_in_in,
   input wire logic byte_valid_in,
   input wire logic fill_done_in,
   // state seen by the data path
   output logic flow_direction_out,
   output logic write_buffer_select_out,
   output logic fill_busy_out,
   output logic interrupt_out
);

   if (BUF_BYTES < 1 || BUF_BYTES > (1 << `BEC_CNT_W) - 1) begin : g_bad_bytes
      $error("buffer size does not fit the byte count width");
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic hit(input logic [`BEC_ADDR_W-1:0] a,
                                input logic [`BEC_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic [`BEC_DATA_W-1:0] count_byte(input bec_pkg::bec_count_t c,
                                                        input logic high);
      logic [15:0] wide;
      wide = 16'(c);
      count_byte = high ? wide[15:8] : wide[7:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   bec_pkg::bec_top_s state_reg;
   bec_pkg::bec_top_s state_next;

   bec_pkg::bec_count_t count_a;
   bec_pkg::bec_count_t count_b;
   logic token_err;
   logic ctl_wr;
   logic sel_wr;
   logic auto_flip;
   logic new_sel;
   logic clear_a;
   logic clear_b;
   logic inc_a;
   logic inc_b;
   logic [`BEC_STAT_W-1:0] events;

   ////////////////////////////////////////////////////////////////////////////
   // write decode and buffer selection

   assign ctl_wr = wr_in && hit(addr_in, `BEC_OFS_CTL);

   assign sel_wr = ctl_wr && wdata_in[`BEC_CTL_QUAL_BIT];

   assign auto_flip = state_reg.auto_alt && fill_done_in && !sel_wr;

   // a software select write beats an alternation in the same cycle
   assign new_sel = sel_wr ? wdata_in[`BEC_CTL_SEL_BIT] : !state_reg.wr_sel;

   assign clear_a = (sel_wr || auto_flip) && !new_sel;

   assign clear_b = (sel_wr || auto_flip) && new_sel;

   // bytes land in whichever buffer the select bit names
   assign inc_a = byte_valid_in && !state_reg.wr_sel;
   assign inc_b = byte_valid_in && state_reg.wr_sel;

   ////////////////////////////////////////////////////////////////////////////
   // byte counters and token checking

   bec_byte_counter #(
      .DEPTH(BUF_BYTES)
   ) u_count_a (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .clear_in(clear_a),
      .inc_in(inc_a),
      .count_out(count_a)
   );

   bec_byte_counter #(
      .DEPTH(BUF_BYTES)
   ) u_count_b (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .clear_in(clear_b),
      .inc_in(inc_b),
      .count_out(count_b)
   );

   bec_token_check u_token (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .token_valid_in(token_valid_in),
      .token_is_in_in(token_is_in_in),
      .flow_dir_in(state_reg.flow_dir),
      .error_pulse_out(token_err)
   );

   ////////////////////////////////////////////////////////////////////////////
   // events feeding the sticky status bits

   always_comb begin
      events = '0;
      events[`BEC_ST_ERR_BIT] = token_err;
      events[`BEC_ST_DONE_A_BIT] = fill_done_in && !state_reg.wr_sel;
      events[`BEC_ST_DONE_B_BIT] = fill_done_in && state_reg.wr_sel;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      state_next = state_reg;
      state_next.rdata = '0;

      if (ctl_wr) begin
         state_next.flow_dir = wdata_in[`BEC_CTL_DIR_BIT];
      end

      if (sel_wr) begin
         state_next.wr_sel = wdata_in[`BEC_CTL_SEL_BIT];
      end else if (auto_flip) begin
         state_next.wr_sel = !state_reg.wr_sel;
      end

      if (wr_in && hit(addr_in, `BEC_OFS_DISK_CTL)) begin
         state_next.auto_alt = wdata_in[`BEC_DISK_AUTO_BIT];
      end

      if (wr_in && hit(addr_in, `BEC_OFS_MASK)) begin
         state_next.mask = wdata_in[`BEC_STAT_W-1:0];
      end

      // write-one-to-clear; a new event in the same cycle wins
      if (wr_in && hit(addr_in, `BEC_OFS_STATUS)) begin
         state_next.status = state_reg.status & ~wdata_in[`BEC_STAT_W-1:0];
      end
      state_next.status = state_next.status | events;

      // a fill is busy from its first byte to its done pulse
      case (state_reg.fill)
         bec_pkg::BEC_FILL_IDLE: begin
            if (byte_valid_in && !fill_done_in) begin
               state_next.fill = bec_pkg::BEC_FILL_BUSY;
            end
         end
         bec_pkg::BEC_FILL_BUSY: begin
            if (fill_done_in) begin
               state_next.fill = bec_pkg::BEC_FILL_IDLE;
            end
         end
         default: begin
            state_next.fill = bec_pkg::BEC_FILL_IDLE;
         end
      endcase

      if (rd_in) begin
         if (hit(addr_in, `BEC_OFS_CTL)) begin
            state_next.rdata = '0;
            state_next.rdata[`BEC_CTL_DIR_BIT] = state_reg.flow_dir;
            state_next.rdata[`BEC_CTL_SEL_BIT] = state_reg.wr_sel;
         end else if (hit(addr_in, `BEC_OFS_STATUS)) begin
            state_next.rdata[`BEC_STAT_W-1:0] = state_reg.status;
         end else if (hit(addr_in, `BEC_OFS_MASK)) begin
            state_next.rdata[`BEC_STAT_W-1:0] = state_reg.mask;
         end else if (hit(addr_in, `BEC_OFS_DISK_CTL)) begin
            state_next.rdata[`BEC_DISK_AUTO_BIT] = state_reg.auto_alt;
         end else if (hit(addr_in, `BEC_OFS_CNT_A_LO)) begin
            state_next.rdata = count_byte(count_a, 1'b0);
         end else if (hit(addr_in, `BEC_OFS_CNT_A_HI)) begin
            state_next.rdata = count_byte(count_a, 1'b1);
         end else if (hit(addr_in, `BEC_OFS_CNT_B_LO)) begin
            state_next.rdata = count_byte(count_b, 1'b0);
         end else if (hit(addr_in, `BEC_OFS_CNT_B_HI)) begin
            state_next.rdata = count_byte(count_b, 1'b1);
         end else begin
            state_next.rdata = '0;
         end
      end

      // interrupt is registered from the next status, so it tracks status exactly
      state_next.irq = |(state_next.status & state_next.mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         state_reg <= '0;
         state_reg.flow_dir <= 1'(`BEC_CTL_RESET >> `BEC_CTL_DIR_BIT);
         state_reg.wr_sel <= 1'b0;
         state_reg.mask <= `BEC_MASK_RESET;
         state_reg.fill <= bec_pkg::BEC_FILL_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata_out = state_reg.rdata;
   assign flow_direction_out = state_reg.flow_dir;
   assign write_buffer_select_out = state_reg.wr_sel;
   assign fill_busy_out = (state_reg.fill == bec_pkg::BEC_FILL_BUSY);
   assign interrupt_out = state_reg.irq;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_in);
   endclocking

   default disable iff (!reset_n_in);

   chk_dir_write_takes: assert property (
      ctl_wr |=> flow_direction_out == $past(wdata_in[`BEC_CTL_DIR_BIT]))
      else $error("direction bit not taken from control write");

   chk_sel_unqualified_hold: assert property (
      (ctl_wr && !wdata_in[`BEC_CTL_QUAL_BIT] && !auto_flip)
      |=> $stable(write_buffer_select_out))
      else $error("select changed on unqualified write");

   chk_sel_qualified_take: assert property (
      sel_wr |=> write_buffer_select_out == $past(wdata_in[`BEC_CTL_SEL_BIT]))
      else $error("qualified select write ignored");

   chk_qual_reads_zero: assert property (
      (rd_in && hit(addr_in, `BEC_OFS_CTL)) |=> rdata_out[`BEC_CTL_QUAL_BIT] == 1'b0)
      else $error("qualifier bit read back nonzero");

   chk_sel_a_clears: assert property (
      (sel_wr && !wdata_in[`BEC_CTL_SEL_BIT]) |=> count_a == '0)
      else $error("selecting buffer A left its count");

   chk_sel_b_clears: assert property (
      (sel_wr && wdata_in[`BEC_CTL_SEL_BIT]) |=> count_b == '0)
      else $error("selecting buffer B left its count");

   chk_sel_readback: assert property (
      (rd_in && hit(addr_in, `BEC_OFS_CTL))
      |=> rdata_out[`BEC_CTL_SEL_BIT] == $past(write_buffer_select_out))
      else $error("select bit read back wrong");

   chk_auto_flip_sel: assert property (
      auto_flip |=> write_buffer_select_out != $past(write_buffer_select_out))
      else $error("auto alternation did not flip select");

   chk_err_reaches_status: assert property (
      (token_valid_in && flow_direction_out && !token_is_in_in)
      |-> ##2 state_reg.status[`BEC_ST_ERR_BIT])
      else $error("token error never reached status");

   chk_read_one_cycle: assert property (
      !rd_in |=> rdata_out == '0)
      else $error("read data stood outside its cycle");

   chk_reset_values: assert property (
      @(posedge clk_in) disable iff (1'b0)
      !reset_n_in |=> (!flow_direction_out && !write_buffer_select_out && !interrupt_out))
      else $error("reset did not clear direction and select");

   chk_reset_counts: assert property (
      @(posedge clk_in) disable iff (1'b0)
      !reset_n_in |=> (count_a == '0 && count_b == '0 && rdata_out == '0 && !fill_busy_out))
      else $error("reset did not clear counts and read data");

   chk_dir_unwritten_hold: assert property (
      !ctl_wr |=> $stable(flow_direction_out))
      else $error("direction changed without a control write");

   chk_sel_idle_hold: assert property (
      (!sel_wr && !auto_flip) |=> $stable(write_buffer_select_out))
      else $error("select changed with no write and no fill end");

   chk_auto_flip_clears: assert property (
      auto_flip |=> (write_buffer_select_out ? count_b == '0 : count_a == '0))
      else $error("alternation left the new buffer count");

   chk_count_a_hold: assert property (
      (write_buffer_select_out && !clear_a) |=> $stable(count_a))
      else $error("buffer A count moved while B was filled");

   chk_count_b_hold: assert property (
      (!write_buffer_select_out && !clear_b) |=> $stable(count_b))
      else $error("buffer B count moved while A was filled");

   chk_err_status_sticks: assert property (
      (state_reg.status[`BEC_ST_ERR_BIT]
       && !(wr_in && hit(addr_in, `BEC_OFS_STATUS) && wdata_in[`BEC_ST_ERR_BIT]))
      |=> state_reg.status[`BEC_ST_ERR_BIT])
      else $error("error status bit dropped without a clear");

   chk_irq_tracks_status: assert property (
      interrupt_out == |(state_reg.status & state_reg.mask))
      else $error("interrupt does not follow masked status");

   chk_busy_after_byte: assert property (
      (byte_valid_in && !fill_done_in) |=> fill_busy_out)
      else $error("fill not busy after a byte");

   chk_done_ends_busy: assert property (
      fill_done_in |=> !fill_busy_out)
      else $error("fill still busy after its end");

   chk_done_a_status: assert property (
      (fill_done_in && !write_buffer_select_out) |=> state_reg.status[`BEC_ST_DONE_A_BIT])
      else $error("fill end of buffer A not recorded");

   chk_done_b_status: assert property (
      (fill_done_in && write_buffer_select_out) |=> state_reg.status[`BEC_ST_DONE_B_BIT])
      else $error("fill end of buffer B not recorded");

   chk_mask_write_takes: assert property (
      (wr_in && hit(addr_in, `BEC_OFS_MASK))
      |=> state_reg.mask == $past(wdata_in[`BEC_STAT_W-1:0]))
      else $error("mask write not taken");

   chk_auto_write_takes: assert property (
      (wr_in && hit(addr_in, `BEC_OFS_DISK_CTL))
      |=> state_reg.auto_alt == $past(wdata_in[`BEC_DISK_AUTO_BIT]))
      else $error("alternation enable write not taken");

endmodule

// >>> testbench/tb_bec_top.sv
// Purpose: self-checking bench for the bulk endpoint control and byte count registers
// Assumes: register strobes are one cycle; read data stand in the cycle after the strobe
// Notes: buffer depth is shrunk to 16 so the saturation case stays short
`include "bec_cfg.svh"

module tb_bec_top;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int BUF = 16;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [`BEC_ADDR_W-1:0] addr_in = 8'h00;
   logic [`BEC_DATA_W-1:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic token_valid_in = 1'b0;
   logic token_is_in_in = 1'b0;
   logic byte_valid_in = 1'b0;
   logic fill_done_in = 1'b0;
   logic [`BEC_DATA_W-1:0] rdata_out;
   logic flow_direction_out;
   logic write_buffer_select_out;
   logic fill_busy_out;
   logic interrupt_out;
   int mismatches = 0;
   int num_checks = 0;

   always #4 clk_in = ~clk_in;

   bec_top #(.BUF_BYTES(BUF)) dut_u (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .addr_in(addr_in),
      .wdata_in(wdata_in),
      .wr_in(wr_in),
      .rd_in(rd_in),
      .rdata_out(rdata_out),
      .token_valid_in(token_valid_in),
      .token_is_in_in(token_is_in_in),
      .byte_valid_in(byte_valid_in),
      .fill_done_in(fill_done_in),
      .flow_direction_out(flow_direction_out),
      .write_buffer_select_out(write_buffer_select_out),
      .fill_busy_out(fill_busy_out),
      .interrupt_out(interrupt_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (mismatches == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk(name, exp, rdata_out);
   endtask

   task automatic cnt(input logic [7:0] lo, input logic [9:0] exp, input string name);
      rd(lo, exp[7:0], name);
      rd(lo + 8'h01, {6'h00, exp[9:8]}, name);
   endtask

   // one spare edge lets a registered level settle before it is judged
   task automatic outs(input logic [3:0] exp);
      @(posedge clk_in);
      #1;
      chk("dir sel busy irq", {4'h0, exp},
          {4'h0, flow_direction_out, write_buffer_select_out, fill_busy_out, interrupt_out});
   endtask

   task automatic tok(input logic is_in);
      @(posedge clk_in);
      token_valid_in <= 1'b1;
      token_is_in_in <= is_in;
      @(posedge clk_in);
      token_valid_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
   endtask

   task automatic bytes(input int n);
      @(posedge clk_in);
      byte_valid_in <= 1'b1;
      repeat (n) @(posedge clk_in);
      byte_valid_in <= 1'b0;
      #1;
   endtask

   task automatic done();
      @(posedge clk_in);
      fill_done_in <= 1'b1;
      @(posedge clk_in);
      fill_done_in <= 1'b0;
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // the sequence needs a few hundred cycles; a hang is stopped at the 5000-cycle run limit
   initial begin
      repeat (5000) @(posedge clk_in);
      mismatches++;
      test_done();
   end

   initial begin
      repeat (12) @(posedge clk_in);
      reset_n_in <= 1'b1;
      #1;
      outs(4'h0);
      rd(`BEC_OFS_CTL, `BEC_CTL_RESET, "ctl reset");
      rd(`BEC_OFS_STATUS, 8'h00, "status reset");
      rd(`BEC_OFS_MASK, 8'h00, "mask reset");
      cnt(`BEC_OFS_CNT_A_LO, 10'h000, "count a reset");
      cnt(`BEC_OFS_CNT_B_LO, 10'h000, "count b reset");
      wr(`BEC_OFS_CTL, 8'h80);
      outs(4'b1000);
      wr(`BEC_OFS_CTL, 8'ha0);
      outs(4'b1000);
      rd(`BEC_OFS_CTL, 8'h80, "ctl select unqualified");
      wr(`BEC_OFS_CTL, 8'he0);
      outs(4'b1100);
      rd(`BEC_OFS_CTL, 8'ha0, "ctl qualifier reads zero");
      // wrong token type per direction
      tok(1'b1);
      rd(`BEC_OFS_STATUS, 8'h00, "in token dir one");
      tok(1'b0);
      rd(`BEC_OFS_STATUS, 8'h01, "out token dir one");
      wr(`BEC_OFS_STATUS, 8'h01);
      rd(`BEC_OFS_STATUS, 8'h00, "error cleared");
      wr(`BEC_OFS_CTL, 8'h40);
      outs(4'b0000);
      tok(1'b0);
      rd(`BEC_OFS_STATUS, 8'h00, "out token dir zero");
      wr(`BEC_OFS_MASK, 8'h01);
      tok(1'b1);
      outs(4'b0001);
      rd(`BEC_OFS_STATUS, 8'h01, "in token dir zero");
      wr(`BEC_OFS_MASK, 8'h00);
      outs(4'b0000);
      wr(`BEC_OFS_MASK, 8'h01);
      outs(4'b0001);
      wr(`BEC_OFS_STATUS, 8'h01);
      outs(4'b0000);
      rd(`BEC_OFS_MASK, 8'h01, "mask readback");
      wr(`BEC_OFS_MASK, 8'h00);
      // fills into A then B, counts kept apart
      bytes(5);
      outs(4'b0010);
      done();
      outs(4'b0000);
      rd(`BEC_OFS_STATUS, 8'h02, "fill a done");
      cnt(`BEC_OFS_CNT_A_LO, 10'd5, "count a fill");
      wr(`BEC_OFS_STATUS, 8'h02);
      wr(`BEC_OFS_CTL, 8'h60);
      outs(4'b0100);
      bytes(3);
      done();
      rd(`BEC_OFS_STATUS, 8'h04, "fill b done");
      cnt(`BEC_OFS_CNT_B_LO, 10'd3, "count b fill");
      cnt(`BEC_OFS_CNT_A_LO, 10'd5, "count a kept");
      rd(`BEC_OFS_CTL, 8'h20, "ctl last filled b");
      wr(`BEC_OFS_CTL, 8'h40);
      cnt(`BEC_OFS_CNT_A_LO, 10'd0, "count a cleared");
      cnt(`BEC_OFS_CNT_B_LO, 10'd3, "count b untouched");
      wr(`BEC_OFS_CTL, 8'h60);
      cnt(`BEC_OFS_CNT_B_LO, 10'd0, "count b cleared");
      wr(`BEC_OFS_CTL, 8'h40);
      bytes(BUF + 2);
      done();
      cnt(`BEC_OFS_CNT_A_LO, 10'(BUF), "count a saturates");
      // automatic alternation flips the select at each fill end
      wr(`BEC_OFS_DISK_CTL, 8'h08);
      rd(`BEC_OFS_DISK_CTL, 8'h08, "disk ctl readback");
      wr(`BEC_OFS_CTL, 8'h40);
      bytes(2);
      done();
      outs(4'b0100);
      rd(`BEC_OFS_CTL, 8'h20, "auto select b");
      cnt(`BEC_OFS_CNT_A_LO, 10'd2, "auto count a");
      bytes(3);
      done();
      outs(4'b0000);
      cnt(`BEC_OFS_CNT_A_LO, 10'd0, "auto clears a");
      cnt(`BEC_OFS_CNT_B_LO, 10'd3, "auto count b");
      wr(`BEC_OFS_DISK_CTL, 8'h00);
      // unmapped place, and read data standing one cycle
      wr(8'h00, 8'hff);
      rd(8'h00, 8'h00, "unmapped read");
      rd(`BEC_OFS_CTL, 8'h00, "ctl after unmapped write");
      @(posedge clk_in);
      #1;
      chk("read data after stand", 8'h00, rdata_out);
      // second reset in mid-run
      wr(`BEC_OFS_CTL, 8'he0);
      @(posedge clk_in);
      reset_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      reset_n_in <= 1'b1;
      #1;
      outs(4'h0);
      rd(`BEC_OFS_CTL, 8'h00, "ctl second reset");
      test_done();
   end
endmodule
